// File: src/apcs_cfg.svh
// apcs_cfg.svh: register offsets, field positions, reset values and timing counts.
// assumes: included by bare name from the package and the design modules.
`ifndef APCS_CFG_SVH
`define APCS_CFG_SVH

// wishbone byte offsets
`define APCS_CTRL_OFS 4'h0
`define APCS_STAT_OFS 4'h4
// control field positions
`define APCS_ON_BIT 15
`define APCS_TRIG_BIT 10
`define APCS_RESULT_FORMAT_SELECT_BIT 8
`define APCS_EIE_BIT 7
`define APCS_ORDER_BIT 6
`define APCS_SEQ_BIT 5
`define APCS_FREE_BIT 4
`define APCS_DIV_LSB 0
// masks of bits that exist
`define APCS_CTRL_MASK 16'h85F7
`define APCS_STAT_MASK 16'h007F
// reset values
`define APCS_DIV_RESET 3'h3
`define APCS_CTRL_RESET 16'h0003
// dedicated sample phase length in divided clock ticks
`define APCS_SAMPLE_TICKS 2'h2

`endif

// File: src/apcs_clkdiv.sv
// apcs_clkdiv.sv: converter clock divider, one tick every div+1 source cycles.
// assumes: div only changes while the converter is off.
`timescale 1ns/1ps

module apcs_clkdiv
  import apcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] div_i,
  // divided tick
  output logic tick_o
);

  typedef struct packed {
    logic [2:0] cnt;
    logic tick;
  } apcs_div_st_t;

  apcs_div_st_t st_reg;
  apcs_div_st_t st_next;

  // count 0..div, tick when wrapping
  always_comb
  begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run_i)
    begin
      st_next.cnt = 3'h0;
    end
    else if (st_reg.cnt >= div_i)
    begin
      st_next.cnt = 3'h0;
      st_next.tick = 1'b1;
    end
    else
    begin
      st_next.cnt = st_reg.cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign tick_o = st_reg.tick;

endmodule

// File: src/apcs_pkg.sv
// apcs_pkg.sv: types shared by the pair control modules.
// assumes: apcs_cfg.svh on the include path.
`include "apcs_cfg.svh"

package apcs_pkg;

  // conversion sequencer states, one-hot
  typedef enum logic [4:0] {
    APCS_IDLE = 5'b0_0001,
    APCS_SAMP = 5'b0_0010,
    APCS_CONV1 = 5'b0_0100,
    APCS_CONV2 = 5'b0_1000,
    APCS_DONE = 5'b1_0000
  } apcs_state_t;

  // handshake with the analog side
  typedef struct packed {
    logic ded_sample;
    logic shr_sample;
    logic conv_start;
    logic conv_second;
    logic conv_odd;
  } apcs_ana_t;

  // settings decoded from the control register
  typedef struct packed {
    logic on;
    logic trig;
    logic frac;
    logic early;
    logic order;
    logic seq;
    logic free_run;
    logic [2:0] div;
  } apcs_cfg_t;

endpackage

// File: src/apcs_top.sv
// apcs_top.sv: pair converter control and status with a classic wishbone slave.
// assumes: triggers and analog done come from the same clock domain; raw data
// is 10 bits from the SAR.
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "apcs_cfg.svh"

// Function
// RULE_01: soft trigger bit 10 starts software pairs; software clears it itself.
// RULE_02: format 1 gives left-justified fractional, 0 right-justified integer.
// RULE_03: early select raises pair interrupt after first conversion, else second.
// RULE_04: order bit picks odd or even input first.
// RULE_05: sequential mode samples shared hold at second or first conversion by order.
// RULE_06: simultaneous mode samples shared hold with dedicated, else next cycle.
// RULE_07: free-running dedicated hold samples until a trigger ends it.
// RULE_08: otherwise sampling starts on trigger and lasts two divided clocks.
// RULE_09: divider field divides by value plus one; reset value 011.
// RULE_10: settings writes are ignored while the converter is on.
// RULE_11: order and sequential bits absent unless built with one SAR.
// RULE_12: each of seven pair ready flags sets when its data is buffered.
// RULE_13: ready flag clears only on a written zero; hardware set wins.
// RULE_14: unimplemented status bits 15-7 and control bits 9, 3 read zero.
module apcs_top
  import apcs_pkg::*;
#(
  parameter int PAIRS = 7,
  parameter bit ONE_SAR = 1'b1
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trigger sources per pair
  input wire logic [PAIRS-1:0] hw_trig_i,
  input wire logic [PAIRS-1:0] sw_trig_sel_i,
  // analog side
  input wire logic conv_done_i,
  input wire logic [9:0] conv_data_i,
  output apcs_pkg::apcs_ana_t ana_o,
  // results
  output logic [15:0] result_o,
  output logic result_valid_o,
  output logic [2:0] result_pair_o,
  output logic [PAIRS-1:0] pair_irq_o
);

  typedef struct packed {
    apcs_cfg_t cfg;
    logic [PAIRS-1:0] ready;
    apcs_state_t state;
    logic [PAIRS-1:0] pend;
    logic [2:0] pair;
    logic [1:0] samp_cnt;
    logic shr_late;
    apcs_ana_t ana;
    logic [15:0] result;
    logic result_valid;
    logic [PAIRS-1:0] irq;
    logic [31:0] dat;
    logic ack;
  } apcs_st_t;

  apcs_st_t st_reg;
  apcs_st_t st_next;
  logic tick;
  logic [15:0] ctrl_rd;
  logic [15:0] stat_rd;
  logic [15:0] wdat;
  logic [PAIRS-1:0] trig_any;
  logic [PAIRS-1:0] trig_low;
  logic first_odd;
  logic div_run;
  logic [15:0] fmt_data;

  // divider runs only around the sampling phase, so that it always starts
  // from zero and two ticks are exactly two whole divided clocks; a free
  // running divider would cut the first divided clock short by its phase
  always_comb
  begin
    div_run = 1'b0;
    if (st_reg.cfg.on)
    begin
      if (st_reg.state == APCS_SAMP)
        div_run = 1'b1; // [RULE_08]
      else if (st_reg.state == APCS_IDLE && st_reg.pend != '0 && !st_reg.cfg.free_run)
        div_run = 1'b1; // [RULE_08]
    end
  end

  // place the raw code left-justified (fractional) or right-justified (integer)
  always_comb
  begin
    if (st_reg.cfg.frac)
      fmt_data = {conv_data_i, 6'h00}; // [RULE_02]
    else
      fmt_data = {6'h00, conv_data_i}; // [RULE_02]
  end

  // divided converter clock
  apcs_clkdiv u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(div_run),
    .div_i(st_reg.cfg.div), // [RULE_09]
    .tick_o(tick)
  );

  // register read views; absent bits stay zero
  always_comb
  begin
    ctrl_rd = 16'h0000; // [RULE_14]
    ctrl_rd[`APCS_ON_BIT] = st_reg.cfg.on;
    ctrl_rd[`APCS_TRIG_BIT] = st_reg.cfg.trig;
    ctrl_rd[`APCS_RESULT_FORMAT_SELECT_BIT] = st_reg.cfg.frac;
    ctrl_rd[`APCS_EIE_BIT] = st_reg.cfg.early;
    ctrl_rd[`APCS_ORDER_BIT] = st_reg.cfg.order;
    ctrl_rd[`APCS_SEQ_BIT] = st_reg.cfg.seq;
    ctrl_rd[`APCS_FREE_BIT] = st_reg.cfg.free_run;
    ctrl_rd[`APCS_DIV_LSB +: 3] = st_reg.cfg.div;
    stat_rd = 16'h0000; // [RULE_14]
    stat_rd[PAIRS-1:0] = st_reg.ready;
  end

  // trigger sources: hardware pins or the global soft trigger
  assign trig_any = hw_trig_i | (sw_trig_sel_i & {PAIRS{st_reg.cfg.trig}}); // [RULE_01]
  assign trig_low = trig_any & ~(trig_any - 1'b1);
  assign first_odd = ONE_SAR ? st_reg.cfg.order : 1'b0; // [RULE_04] [RULE_11]
  assign wdat = wb_dat_i[15:0];

  // main next-state logic
  always_comb
  begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.result_valid = 1'b0;
    st_next.irq = '0;
    st_next.ana.shr_sample = 1'b0;
    st_next.ana.conv_start = 1'b0;
    // wishbone slave, one wait cycle then ack for a single cycle
    if (wb_cyc_i && wb_stb_i && !st_reg.ack)
    begin
      st_next.ack = 1'b1;
      st_next.dat = 32'h0000_0000;
      if (wb_adr_i == `APCS_CTRL_OFS)
        st_next.dat[15:0] = ctrl_rd;
      else if (wb_adr_i == `APCS_STAT_OFS)
        st_next.dat[15:0] = stat_rd;
      if (wb_we_i && wb_adr_i == `APCS_CTRL_OFS)
      begin
        if (wb_sel_i[1])
        begin
          st_next.cfg.on = wdat[`APCS_ON_BIT];
          st_next.cfg.trig = wdat[`APCS_TRIG_BIT]; // [RULE_01]
          if (!st_reg.cfg.on) // [RULE_10]
            st_next.cfg.frac = wdat[`APCS_RESULT_FORMAT_SELECT_BIT];
        end
        if (wb_sel_i[0] && !st_reg.cfg.on) // [RULE_10]
        begin
          st_next.cfg.early = wdat[`APCS_EIE_BIT];
          st_next.cfg.order = ONE_SAR & wdat[`APCS_ORDER_BIT]; // [RULE_11]
          st_next.cfg.seq = ONE_SAR & wdat[`APCS_SEQ_BIT]; // [RULE_11]
          st_next.cfg.free_run = wdat[`APCS_FREE_BIT];
          st_next.cfg.div = wdat[`APCS_DIV_LSB +: 3];
        end
      end
      if (wb_we_i && wb_adr_i == `APCS_STAT_OFS && wb_sel_i[0])
        st_next.ready = st_reg.ready & wdat[PAIRS-1:0]; // [RULE_13]
    end
    // latch trigger requests while on
    if (st_reg.cfg.on)
      st_next.pend = st_next.pend | trig_any;
    else
      st_next.pend = '0;
    // pair sequencer
    case (st_reg.state)
      APCS_IDLE:
      begin
        st_next.ana.ded_sample = st_reg.cfg.on && st_reg.cfg.free_run; // [RULE_07]
        if (st_reg.cfg.on && st_reg.pend != '0)
        begin
          for (int i = PAIRS - 1; i >= 0; i--)
            if (st_reg.pend[i])
              st_next.pair = 3'(i);
          st_next.pend = st_next.pend & ~(st_reg.pend & ~(st_reg.pend - 1'b1));
          st_next.samp_cnt = 2'h0;
          st_next.ana.conv_odd = first_odd;
          if (st_reg.cfg.free_run)
          begin
            st_next.ana.ded_sample = 1'b0; // [RULE_07]
            st_next.state = APCS_CONV1;
            st_next.ana.conv_start = 1'b1;
            st_next.ana.conv_second = 1'b0;
            st_next.shr_late = st_reg.cfg.seq && !st_reg.cfg.order; // [RULE_05]
            st_next.ana.shr_sample = !(st_reg.cfg.seq && !st_reg.cfg.order); // [RULE_05] [RULE_06]
          end
          else
          begin
            st_next.ana.ded_sample = 1'b1; // [RULE_08]
            st_next.state = APCS_SAMP;
          end
        end
      end
      APCS_SAMP:
      begin
        if (tick)
          st_next.samp_cnt = st_reg.samp_cnt + 2'h1;
        if (tick && st_reg.samp_cnt == `APCS_SAMPLE_TICKS - 2'h1) // [RULE_08]
        begin
          st_next.ana.ded_sample = 1'b0;
          st_next.state = APCS_CONV1;
          st_next.ana.conv_start = 1'b1;
          st_next.ana.conv_second = 1'b0;
          st_next.shr_late = st_reg.cfg.seq && !st_reg.cfg.order; // [RULE_05]
          st_next.ana.shr_sample = !(st_reg.cfg.seq && !st_reg.cfg.order); // [RULE_06]
        end
      end
      APCS_CONV1:
      begin
        if (conv_done_i)
        begin
          st_next.result = fmt_data; // [RULE_02]
          st_next.result_valid = 1'b1;
          st_next.irq[st_reg.pair] = st_reg.cfg.early; // [RULE_03]
          st_next.state = APCS_CONV2;
          st_next.ana.conv_start = 1'b1;
          st_next.ana.conv_second = 1'b1;
          st_next.ana.conv_odd = ~st_reg.ana.conv_odd;
          st_next.ana.shr_sample = st_reg.shr_late; // [RULE_05] [RULE_06]
        end
      end
      APCS_CONV2:
      begin
        if (conv_done_i)
        begin
          st_next.result = fmt_data; // [RULE_02]
          st_next.result_valid = 1'b1;
          st_next.irq[st_reg.pair] = !st_reg.cfg.early; // [RULE_03]
          st_next.state = APCS_DONE;
        end
      end
      APCS_DONE:
      begin
        st_next.ready[st_reg.pair] = 1'b1; // [RULE_12] [RULE_13]
        st_next.ana.conv_second = 1'b0;
        st_next.state = APCS_IDLE;
      end
      default:
        st_next.state = APCS_IDLE;
    endcase
    if (!st_reg.cfg.on && st_reg.state != APCS_DONE)
    begin
      st_next.state = APCS_IDLE;
      st_next.ana.ded_sample = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st_reg <= '0;
      st_reg.cfg.div <= `APCS_DIV_RESET; // [RULE_09]
      st_reg.state <= APCS_IDLE;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state register
  assign wb_dat_o = st_reg.dat;
  assign wb_ack_o = st_reg.ack;
  assign ana_o = st_reg.ana;
  assign result_o = st_reg.result;
  assign result_valid_o = st_reg.result_valid;
  assign result_pair_o = st_reg.pair;
  assign pair_irq_o = st_reg.irq;

endmodule

// File: test/apcs_sar_model.sv
// apcs_sar_model.sv: behavioural SAR converter on the far side of the pair control block.
// assumes: same clock as the block; lat_i sets how slowly each conversion answers.
`timescale 1ns/1ps

module apcs_sar_model
  import apcs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // from the control block
  input wire apcs_pkg::apcs_ana_t ana_i,
  input wire logic [3:0] lat_i,
  // conversion result
  output logic done_o,
  output logic [9:0] data_o
);
  int cnt;
  logic odd;
  // count a conversion down; data toggles outside the done pulse so stale values show
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    data_o <= ~data_o;
    if (rst_i)
    begin
      cnt <= 0;
      data_o <= 10'h155;
    end
    else if (ana_i.conv_start)
    begin
      cnt <= int'(lat_i);
      odd <= ana_i.conv_odd;
    end
    else if (cnt == 1)
    begin
      cnt <= 0;
      done_o <= 1'b1;
      data_o <= odd ? 10'h3A5 : 10'h25A;
    end
    else if (cnt > 1)
      cnt <= cnt - 1;
  end
endmodule

// File: test/apcs_top_checker.sv
// apcs_top_checker.sv: concurrent checks on the pair control ports.
// assumes: one clock domain; bound into every apcs_top.
`timescale 1ns/1ps
`include "apcs_cfg.svh"

module apcs_top_checker
  import apcs_pkg::*;
#(
  parameter int PAIRS = 7
)
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // converter side
  input wire logic conv_done_i,
  input wire apcs_pkg::apcs_ana_t ana_o,
  input wire logic [15:0] result_o,
  input wire logic result_valid_o,
  input wire logic [PAIRS-1:0] pair_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // bus handshake
  ack_follows_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  // unused bits read zero
  stat_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `APCS_STAT_OFS
    |-> wb_dat_o[31:7] == 25'h000_0000) else $error("status unused bits set");
  ctrl_unused_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == `APCS_CTRL_OFS
    |-> !wb_dat_o[9] && !wb_dat_o[3] && wb_dat_o[31:16] == 16'h0000)
    else $error("control unused bits set");
  // conversion flow
  valid_after_done_a: assert property (conv_done_i |=> result_valid_o)
    else $error("no result after conversion end");
  fmt_zero_a: assert property (result_valid_o
    |-> result_o[15:10] == 6'h00 || result_o[5:0] == 6'h00) else $error("result not justified");
  irq_after_done_a: assert property (pair_irq_o != '0 |-> $onehot(pair_irq_o)
    && ($past(conv_done_i) || $past(conv_done_i, 2) || $past(conv_done_i, 3)))
    else $error("interrupt without conversion end");
  second_after_first_a: assert property (ana_o.conv_start && ana_o.conv_second
    |-> $past(conv_done_i)) else $error("second conversion started early");
  start_no_sample_a: assert property (ana_o.conv_start |-> !ana_o.ded_sample)
    else $error("dedicated hold still sampling at start");
  shr_pulse_a: assert property (ana_o.shr_sample |=> !ana_o.shr_sample)
    else $error("shared sample longer than a pulse");
  // main scenarios reached
  irq_c: cover property (pair_irq_o != '0);
  shr_c: cover property (ana_o.shr_sample);
  second_c: cover property (ana_o.conv_start && ana_o.conv_second);
endmodule

bind apcs_top apcs_top_checker #(.PAIRS(PAIRS)) chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .conv_done_i, .ana_o, .result_o,
  .result_valid_o, .pair_irq_o);

// File: test/test_adc_pair_control_status.sv
// test_adc_pair_control_status.sv: self-checking bench for the pair control block.
// assumes: apcs_sar_model answers conversions on the analog side.
`timescale 1ns/1ps
`include "apcs_cfg.svh"

module test_adc_pair_control_status;
  import apcs_pkg::*;
  // bus row: write address and data, then read address and expected value
  typedef struct packed {logic [3:0] a; logic [15:0] d; logic [3:0] ra; logic [15:0] e;} apcs_row_t;
  // conversion case: pair, divider, {frac, early, order, seq, free}
  typedef struct packed {logic [2:0] p; logic [2:0] div; logic [4:0] f;} apcs_case_t;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h3;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, conv_done_i, result_valid_o;
  logic [9:0] conv_data_i;
  logic [6:0] hw_trig_i = 7'h00;
  logic [6:0] sw_trig_sel_i = 7'h00;
  logic [6:0] pair_irq_o;
  logic [2:0] result_pair_o;
  logic [3:0] lat = 4'h4;
  apcs_ana_t ana_o;
  logic [15:0] result_o, q;
  int mismatches = 0;
  int checks = 0;
  int ndone, irq_at, shr_at, n;
  apcs_row_t rows [6] = '{'{4'h0, 16'hFFFF, 4'h0, 16'h85F7}, '{4'h0, 16'h0000, 4'h0, 16'h01F7},
    '{4'h0, 16'h0000, 4'h0, 16'h0000}, '{4'h8, 16'hFFFF, 4'h8, 16'h0000},
    '{4'h0, 16'h0007, 4'h0, 16'h0007}, '{4'h4, 16'hFFFF, 4'h4, 16'h0000}};
  apcs_case_t cases [4] = '{'{3'h0, 3'h3, 5'h02}, '{3'h6, 3'h0, 5'h1E},
    '{3'h3, 3'h7, 5'h09}, '{3'h5, 3'h1, 5'h14}};

  apcs_top dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .hw_trig_i, .sw_trig_sel_i, .conv_done_i, .conv_data_i,
    .ana_o, .result_o, .result_valid_o, .result_pair_o, .pair_irq_o);
  apcs_sar_model sar_u (.clk_i, .rst_i, .ana_i(ana_o), .lat_i(lat), .done_o(conv_done_i),
    .data_o(conv_data_i));

  // clock
  initial forever #4 clk_i = ~clk_i;
  // note how many conversions had ended when interrupt and shared sample came
  always @(posedge clk_i)
  begin
    if (conv_done_i === 1'b1) ndone++;
    if (pair_irq_o !== 7'h00) irq_at = ndone;
    if (ana_o.shr_sample === 1'b1) shr_at = ndone;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk(wb_dat_o[31:16], 16'h0000);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    wb(1'b0, a, 16'h0000);
    chk(q, e);
  endtask

  task automatic run(input apcs_case_t c);
    logic [9:0] d;
    wb(1'b1, `APCS_CTRL_OFS, 16'h0000);
    wb(1'b1, `APCS_CTRL_OFS, {1'b1, 6'h00, c.f, 1'b0, c.div});
    lat <= 4'h2 + {1'b0, c.div};
    repeat (3) @(posedge clk_i);
    if (c.f[0]) chk({15'h0000, ana_o.ded_sample}, 16'h0001);
    ndone = 0;
    irq_at = 9;
    shr_at = 9;
    hw_trig_i[c.p] <= 1'b1;
    @(posedge clk_i);
    hw_trig_i <= 7'h00;
    if (!c.f[0])
    begin
      n = 0;
      do @(posedge clk_i); while (ana_o.ded_sample !== 1'b1 && ++n < 40);
      n = 0;
      while (ana_o.ded_sample === 1'b1 && n < 40)
      begin
        n++;
        @(posedge clk_i);
      end
      chk(16'(n), 16'(2 * (c.div + 1)));
    end
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      do @(posedge clk_i); while (result_valid_o !== 1'b1 && ++n < 300);
      d = (c.f[2] ^ (k == 1)) ? 10'h3A5 : 10'h25A;
      chk(result_o, c.f[4] ? {d, 6'h00} : {6'h00, d});
      chk(16'(result_pair_o), 16'(c.p));
    end
    repeat (4) @(posedge clk_i);
    chk(16'(irq_at), c.f[3] ? 16'h0001 : 16'h0002);
    chk(16'(shr_at), {15'h0000, c.f[1] & ~c.f[2]});
    rd(`APCS_STAT_OFS, 16'(1 << c.p));
    wb(1'b1, `APCS_STAT_OFS, 16'hFFFF);
    rd(`APCS_STAT_OFS, 16'(1 << c.p));
    wb(1'b1, `APCS_STAT_OFS, 16'h0000);
    rd(`APCS_STAT_OFS, 16'h0000);
    $display("conversion case for pair %0d done", c.p);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // main sequence: register rows, conversion cases, soft trigger, reset with the converter off
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`APCS_CTRL_OFS, 16'h0003);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].a, rows[i].d);
      rd(rows[i].ra, rows[i].e);
    end
    $display("register rows done");
    foreach (cases[i]) run(cases[i]);
    wb(1'b1, `APCS_CTRL_OFS, 16'h0000);
    sw_trig_sel_i <= 7'h04;
    wb(1'b1, `APCS_CTRL_OFS, 16'h8403);
    n = 0;
    do @(posedge clk_i); while (pair_irq_o[2] !== 1'b1 && ++n < 300);
    rd(`APCS_CTRL_OFS, 16'h8403);
    wb(1'b1, `APCS_CTRL_OFS, 16'h0003);
    $display("soft trigger test done");
    wb(1'b1, `APCS_CTRL_OFS, 16'h00F4);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`APCS_CTRL_OFS, 16'h0003);
    rd(`APCS_STAT_OFS, 16'h0000);
    $display("reset test done");
    conclude();
  end

  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
